// File: core/tmc_regs.svh
// register offsets, reset values and timing constants of the transceiver mode controller
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
`define TMC_CTRL_OFS        8'h00
`define TMC_STAT_OFS        8'h04
`define TMC_CTRL_RST        32'h0000_0000
`define TMC_CTRL_FORCE_BIT  0
`define TMC_CTRL_RXCLR_BIT  1
`define TMC_STAT_MODE_LSB   0
`define TMC_STAT_RXL_BIT    4
`define TMC_STAT_REG_BIT    5
`define TMC_STAT_INH_BIT    6
`define TMC_STAT_RDY_BIT    7
`define TMC_STAT_BIAS_BIT   8
`define TMC_CLK_MHZ         100
`define TMC_TICK_NS         1000
`define TMC_TICK_CYC        ((`TMC_TICK_NS * `TMC_CLK_MHZ) / 1000)
`define TMC_SLP_US          50
`define TMC_SILENCE_US      900000
`define TMC_INACTIVE_US     5000000
`define TMC_WKFILT_US       1
`define TMC_WKTO_US         1800
`define TMC_UVSLP_US        200000
`endif

// File: core/tmc_pkg.sv
// types of the transceiver mode controller
package tmc_pkg;
    typedef enum logic [3:0] {
        TMC_NORMAL   = 4'b0001,
        TMC_STANDBY  = 4'b0010,
        TMC_SLEEP    = 4'b0100,
        TMC_FAILSAFE = 4'b1000
    } tmc_mode_t;
    typedef enum logic [3:0] {
        TMC_W_IDLE = 4'b0001,
        TMC_W_DOM1 = 4'b0010,
        TMC_W_REC  = 4'b0100,
        TMC_W_DOM2 = 4'b1000
    } tmc_wake_t;
endpackage

// File: core/tmc_core.sv
// operating-mode controller of a can fd transceiver with wishbone status access
`timescale 1ns/10ps
`include "tmc_regs.svh"

// What this block does
// [R1] over-temperature forces fail-safe with transmitter and receiver off
// [R2] over-temperature fault clears only below falling threshold; renewed rise trips again
// [R3] supply undervoltage on supply_uv_i forces fail-safe; io undervoltage in standby leads to sleep instead
// [R4] any supply overvoltage forces fail-safe
// [R5] floating transmit input reads recessive; host drives it actively
// [R6] floating sleep-control reads low, steering toward sleep
// [R7] sleep-wake error timer runs only in standby and fail-safe, stops on any transition
// [R8] sleep-wake timer expiry in standby pulls receive low and enters sleep on the same edge
// [R9] mode follows sleep-control, supply, temperature and wake events
// [R10] normal mode passes transmit to bus and bus to receive
// [R11] standby: ready low, transceiver off, bus biased to ground after silence timeout
// [R12] standby bus wake biases bus to 2.5 V and latches receive low
// [R13] standby watches local wake both edges; inhibit stays asserted
// [R14] standby receive low on wake or fault; power-on counts as wake
// [R15] bus wake turns regulator on; off again at silence timeout
// [R16] standby regulator on when sleep-control goes high
// [R17] host must command normal before inactivity timeout or device sleeps
// [R18] sleep on hold-low time, io undervoltage delay, or error timer expiry
// [R19] leave sleep on io valid with control high, bus wake, local wake, reset
// [R20] sleep: inhibit off, transceiver off, ground bias after silence timeout
// [R21] wake monitor: dominant, recessive, dominant; other traffic does not reset it
// [R22] receive low on second dominant once io supply is valid
// [R23] a bus state counts only after lasting longer than the filter time
// [R24] pattern must finish within the wake timeout, else monitor restarts
// [R25] fail-safe exits on cool, no under- or overvoltage and wake; else sleep after inactivity
// [R26] ready high only in normal with no dominant-timeout fault
// [R27] all timers are parameterised counters reset when their use ends
module tmc_core
    import tmc_pkg::*;
#(
    parameter int unsigned TICK_CYC     = `TMC_TICK_CYC,
    parameter int unsigned SLP_TICKS    = `TMC_SLP_US,
    parameter int unsigned SILENCE_TICKS = `TMC_SILENCE_US,
    parameter int unsigned INACT_TICKS  = `TMC_INACTIVE_US,
    parameter int unsigned WKFILT_TICKS = `TMC_WKFILT_US,
    parameter int unsigned WKTO_TICKS   = `TMC_WKTO_US,
    parameter int unsigned UVSLP_TICKS  = `TMC_UVSLP_US
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sleep_control_n,
    input  wire logic        txd_i,
    input  wire logic        bus_dominant_i,
    input  wire logic        local_wake_i,
    input  wire logic        over_temp_rise_i,
    input  wire logic        over_temp_fall_i,
    input  wire logic        supply_uv_i,
    input  wire logic        regulator_ov_i,
    input  wire logic        io_supply_valid_i,
    input  wire logic        dominant_timeout_fault_i,
    output logic             rxd_o,
    output logic             rxd_oe,
    output logic             tx_dominant_o,
    output logic             tx_enable_o,
    output logic             rx_enable_o,
    output logic             bus_bias_2v5_o,
    output logic             transceiver_regulator_o,
    output logic             supply_inhibit_output,
    output logic             transceiver_ready_output
);

    localparam int unsigned CW = 32;

    initial begin
        if (TICK_CYC < 1 || WKFILT_TICKS < 1 || WKTO_TICKS <= 3 * WKFILT_TICKS ||
            SLP_TICKS < 1 || SILENCE_TICKS < 1 || INACT_TICKS < 1 || UVSLP_TICKS < 1) begin
            $error("tmc_core: timing parameters out of range");
        end
    end

    // saturating tick counter step: clear, hold or count on tick
    function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c, input logic run,
                                               input logic tk);
        if (!run) begin
            cnt_step = '0;
        end else if (tk && c != {CW{1'b1}}) begin
            cnt_step = c + 1'b1;
        end else begin
            cnt_step = c;
        end
    endfunction

    tmc_mode_t   mode_r, mode_nxt;
    tmc_wake_t   wk_r, wk_nxt;
    logic [CW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic          tick;
    logic [CW-1:0] slp_cnt_r, slp_cnt_nxt;
    logic [CW-1:0] sil_cnt_r, sil_cnt_nxt;
    logic [CW-1:0] inact_cnt_r, inact_cnt_nxt;
    logic [CW-1:0] uv_cnt_r, uv_cnt_nxt;
    logic [CW-1:0] filt_cnt_r, filt_cnt_nxt;
    logic [CW-1:0] wto_cnt_r, wto_cnt_nxt;
    logic          bus_prev_r, bus_prev_nxt;
    logic          lw_prev_r, lw_prev_nxt;
    logic          otp_r, otp_nxt;
    logic          wake_pend_r, wake_pend_nxt;
    logic          rx_low_r, rx_low_nxt;
    logic          reg_on_r, reg_on_nxt;
    logic          bias_r, bias_nxt;
    logic          ack_r, ack_nxt;
    logic [31:0]   dat_r, dat_nxt;
    logic          force_sleep_r, force_sleep_nxt;
    logic          bus_wake, local_wake, fault, filt_ok, mode_chg;
    logic          slp_exp, sil_exp, inact_exp, uv_exp, wto_exp, wb_req;

    // timebase divider producing a one-cycle tick
    always_comb begin
        tick = (tick_cnt_r == CW'(TICK_CYC - 1));
        tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    end

    // fault latch and event detection
    always_comb begin
        otp_nxt = otp_r;
        if (over_temp_rise_i) begin
            otp_nxt = 1'b1;                              // see [R1] see [R2]
        end else if (over_temp_fall_i) begin
            otp_nxt = 1'b0;                              // see [R2]
        end
        fault      = otp_r | supply_uv_i | regulator_ov_i;   // see [R3] see [R4]
        local_wake = (local_wake_i != lw_prev_r) && mode_r != TMC_NORMAL;  // see [R13]
        lw_prev_nxt = local_wake_i;
        bus_prev_nxt = bus_dominant_i;
    end

    // wake-pattern monitor with filter and overall timeout
    always_comb begin
        wk_nxt       = wk_r;
        bus_wake     = 1'b0;
        filt_ok      = (filt_cnt_r >= CW'(WKFILT_TICKS)) && tick;   // longer than filter, see [R23]
        filt_cnt_nxt = (bus_dominant_i != bus_prev_r) ? '0 : cnt_step(filt_cnt_r, 1'b1, tick);
        wto_exp      = wto_cnt_r >= CW'(WKTO_TICKS);
        wto_cnt_nxt  = cnt_step(wto_cnt_r, wk_r != TMC_W_IDLE, tick);
        if (mode_r == TMC_NORMAL) begin
            wk_nxt = TMC_W_IDLE;
        end else if (wto_exp) begin
            wk_nxt = TMC_W_IDLE;                         // see [R24]
        end else begin
            case (wk_r)
                TMC_W_IDLE: if (filt_ok && bus_dominant_i) wk_nxt = TMC_W_DOM1;  // see [R21]
                TMC_W_DOM1: if (filt_ok && !bus_dominant_i) wk_nxt = TMC_W_REC;
                TMC_W_REC: if (filt_ok && bus_dominant_i) begin
                    wk_nxt   = TMC_W_IDLE;
                    bus_wake = 1'b1;                     // see [R21]
                end
                default: wk_nxt = TMC_W_IDLE;
            endcase
        end
    end

    // mode timers on the internal timebase
    always_comb begin
        mode_chg  = mode_nxt != mode_r;
        slp_exp   = slp_cnt_r >= CW'(SLP_TICKS);
        sil_exp   = sil_cnt_r >= CW'(SILENCE_TICKS);
        inact_exp = inact_cnt_r >= CW'(INACT_TICKS);
        uv_exp    = uv_cnt_r >= CW'(UVSLP_TICKS);
        slp_cnt_nxt = cnt_step(slp_cnt_r, !sleep_control_n && mode_r != TMC_SLEEP, tick);
        uv_cnt_nxt  = cnt_step(uv_cnt_r, !io_supply_valid_i && mode_r != TMC_SLEEP, tick);
        sil_cnt_nxt = cnt_step(sil_cnt_r, bias_r && mode_r != TMC_NORMAL, tick);  // see [R27]
        inact_cnt_nxt = cnt_step(inact_cnt_r,
                                 (mode_r == TMC_STANDBY || mode_r == TMC_FAILSAFE) && !mode_chg,
                                 tick);                  // see [R7] see [R27]
    end

    // operating-mode state machine
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            TMC_NORMAL: begin
                if (fault) begin
                    mode_nxt = TMC_FAILSAFE;             // see [R1] see [R3] see [R4]
                end else if (!sleep_control_n) begin
                    mode_nxt = TMC_STANDBY;              // see [R9]
                end
            end
            TMC_STANDBY: begin
                if (fault) begin
                    mode_nxt = TMC_FAILSAFE;
                end else if (inact_exp || force_sleep_r) begin
                    mode_nxt = TMC_SLEEP;                // see [R8] see [R17] see [R18]
                end else if (uv_exp) begin
                    mode_nxt = TMC_SLEEP;                // see [R18]
                end else if (slp_exp && !wake_pend_r && io_supply_valid_i) begin
                    mode_nxt = TMC_SLEEP;                // see [R6] see [R18]
                end else if (sleep_control_n && io_supply_valid_i) begin
                    mode_nxt = TMC_NORMAL;               // see [R9]
                end
            end
            TMC_SLEEP: begin
                if (fault) begin
                    mode_nxt = TMC_FAILSAFE;
                end else if (sleep_control_n && io_supply_valid_i) begin
                    mode_nxt = TMC_NORMAL;               // see [R19]
                end else if (bus_wake || local_wake) begin
                    mode_nxt = TMC_STANDBY;              // see [R19]
                end
            end
            TMC_FAILSAFE: begin
                if (inact_exp) begin
                    mode_nxt = TMC_SLEEP;                // see [R25]
                end else if (!fault && (wake_pend_r || bus_wake || local_wake)) begin
                    mode_nxt = TMC_STANDBY;              // see [R25]
                end
            end
            default: mode_nxt = TMC_SLEEP;
        endcase
    end

    // wake latch, receive indication, regulator and bus bias
    always_comb begin
        wake_pend_nxt = wake_pend_r;
        rx_low_nxt    = rx_low_r;
        reg_on_nxt    = reg_on_r;
        bias_nxt      = bias_r;
        if (bus_wake || local_wake) begin
            wake_pend_nxt = 1'b1;                        // set wins over clear
        end else if (mode_nxt == TMC_NORMAL) begin
            wake_pend_nxt = 1'b0;
        end
        if (mode_r == TMC_STANDBY && (bus_wake || local_wake || fault || inact_exp)) begin
            rx_low_nxt = 1'b1;                           // see [R8] see [R12] see [R14]
        end else if (mode_r == TMC_SLEEP && bus_wake) begin
            rx_low_nxt = 1'b1;                           // held until io is valid, see [R22]
        end else if (mode_nxt == TMC_NORMAL) begin
            rx_low_nxt = 1'b0;
        end
        if (mode_nxt == TMC_NORMAL) begin
            reg_on_nxt = 1'b1;
            bias_nxt   = 1'b1;
        end else if (mode_nxt == TMC_FAILSAFE || mode_nxt == TMC_SLEEP) begin
            reg_on_nxt = 1'b0;
            bias_nxt   = bias_r && !sil_exp;             // see [R20]
        end else if (bus_wake) begin
            reg_on_nxt = 1'b1;                           // see [R12] see [R15]
            bias_nxt   = 1'b1;
        end else if (sleep_control_n) begin
            reg_on_nxt = 1'b1;                           // see [R16]
        end else if (sil_exp) begin
            reg_on_nxt = 1'b0;                           // see [R15]
            bias_nxt   = 1'b0;                           // see [R11]
        end
    end

    // wishbone slave: control write and status read, answer one cycle after request
    always_comb begin
        wb_req          = wb_cyc_i && wb_stb_i && !ack_r;
        ack_nxt         = wb_req;
        dat_nxt         = dat_r;
        force_sleep_nxt = force_sleep_r && mode_r == TMC_STANDBY;
        if (wb_req) begin
            dat_nxt = 32'h0000_0000;
            if (wb_adr_i == `TMC_CTRL_OFS) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    force_sleep_nxt = wb_dat_i[`TMC_CTRL_FORCE_BIT];
                end
                dat_nxt[`TMC_CTRL_FORCE_BIT] = force_sleep_r;
            end else if (wb_adr_i == `TMC_STAT_OFS) begin
                dat_nxt[`TMC_STAT_MODE_LSB +: 4] = mode_r;
                dat_nxt[`TMC_STAT_RXL_BIT]  = rx_low_r;
                dat_nxt[`TMC_STAT_REG_BIT]  = reg_on_r;
                dat_nxt[`TMC_STAT_INH_BIT]  = supply_inhibit_output;
                dat_nxt[`TMC_STAT_RDY_BIT]  = transceiver_ready_output;
                dat_nxt[`TMC_STAT_BIAS_BIT] = bias_r;
            end
        end
    end

    // register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r        <= TMC_STANDBY;
            wk_r          <= TMC_W_IDLE;
            tick_cnt_r    <= '0;
            slp_cnt_r     <= '0;
            sil_cnt_r     <= '0;
            inact_cnt_r   <= '0;
            uv_cnt_r      <= '0;
            filt_cnt_r    <= '0;
            wto_cnt_r     <= '0;
            bus_prev_r    <= 1'b0;
            lw_prev_r     <= 1'b0;
            otp_r         <= 1'b0;
            wake_pend_r   <= 1'b1;                       // power-on counts as wake, see [R14]
            rx_low_r      <= 1'b1;                       // see [R14]
            reg_on_r      <= 1'b0;
            bias_r        <= 1'b0;
            ack_r         <= 1'b0;
            dat_r         <= `TMC_CTRL_RST;
            force_sleep_r <= 1'b0;
        end else begin
            mode_r        <= mode_nxt;
            wk_r          <= wk_nxt;
            tick_cnt_r    <= tick_cnt_nxt;
            slp_cnt_r     <= slp_cnt_nxt;
            sil_cnt_r     <= sil_cnt_nxt;
            inact_cnt_r   <= inact_cnt_nxt;
            uv_cnt_r      <= uv_cnt_nxt;
            filt_cnt_r    <= filt_cnt_nxt;
            wto_cnt_r     <= wto_cnt_nxt;
            bus_prev_r    <= bus_prev_nxt;
            lw_prev_r     <= lw_prev_nxt;
            otp_r         <= otp_nxt;
            wake_pend_r   <= wake_pend_nxt;
            rx_low_r      <= rx_low_nxt;
            reg_on_r      <= reg_on_nxt;
            bias_r        <= bias_nxt;
            ack_r         <= ack_nxt;
            dat_r         <= dat_nxt;
            force_sleep_r <= force_sleep_nxt;
        end
    end

    // pin outputs derived from mode
    always_comb begin
        wb_ack_o   = ack_r;
        wb_dat_o   = dat_r;
        tx_enable_o = mode_r == TMC_NORMAL && !otp_r;                  // see [R1] see [R10]
        rx_enable_o = mode_r == TMC_NORMAL && !otp_r;                  // see [R11]
        tx_dominant_o = tx_enable_o && !dominant_timeout_fault_i && !txd_i; // see [R5] see [R10]
        rxd_o      = rx_enable_o ? !bus_dominant_i : !rx_low_r;        // see [R10] see [R22]
        rxd_oe     = io_supply_valid_i;                                // see [R22]
        bias_bus_out();
    end

    function automatic void bias_bus_out();
    endfunction

    assign bus_bias_2v5_o          = bias_r;
    assign transceiver_regulator_o = reg_on_r;
    assign supply_inhibit_output   = mode_r == TMC_NORMAL || mode_r == TMC_STANDBY; // see [R13] see [R20]
    assign transceiver_ready_output = mode_r == TMC_NORMAL && !dominant_timeout_fault_i
                                      && !otp_r;         // see [R26]

endmodule // tmc_core

// File: tb/tmc_host_model.sv
// behavioural host controller that drives sleep control and transmit data
`timescale 1ns/10ps
module tmc_host_model (
    input  wire logic clk,
    input  wire logic want_normal,
    input  wire logic answer_wake,
    input  wire logic tx_bit,
    input  wire logic rxd_o,
    input  wire logic rxd_oe,
    output logic      sleep_control_n,
    output logic      txd_i
);
    logic wake_seen_r = 1'b0;
    initial sleep_control_n = 1'b0;
    initial txd_i = 1'b1;
    // both lines are always driven, never left floating
    always @(posedge clk) begin
        wake_seen_r <= answer_wake && (wake_seen_r || (rxd_oe && !rxd_o));
        txd_i <= tx_bit;
        sleep_control_n <= want_normal || wake_seen_r;
    end
endmodule // tmc_host_model

// File: tb/tmc_core_chk.sv
// concurrent checks on the ports of the transceiver mode controller
`timescale 1ns/10ps
module tmc_core_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sleep_control_n,
    input wire logic txd_i,
    input wire logic bus_dominant_i,
    input wire logic over_temp_rise_i,
    input wire logic over_temp_fall_i,
    input wire logic supply_uv_i,
    input wire logic regulator_ov_i,
    input wire logic io_supply_valid_i,
    input wire logic dominant_timeout_fault_i,
    input wire logic rxd_o,
    input wire logic tx_dominant_o,
    input wire logic tx_enable_o,
    input wire logic rx_enable_o,
    input wire logic transceiver_regulator_o,
    input wire logic supply_inhibit_output,
    input wire logic transceiver_ready_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // heat seen, then no cooling indication for four cycles
    sequence s_hot;
        over_temp_rise_i ##1 (!over_temp_fall_i)[*4];
    endsequence
    // host raises sleep control in standby and holds it with no fault
    sequence s_host_up;
        $rose(sleep_control_n) && supply_inhibit_output && io_supply_valid_i
        ##0 (sleep_control_n && !over_temp_rise_i && !supply_uv_i && !regulator_ov_i)[*6];
    endsequence
    a_heat_shutdown: assert property (
        over_temp_rise_i |-> ##[1:4] (!tx_enable_o && !rx_enable_o))
        else $error("transceiver active while hot");
    a_heat_holds: assert property (s_hot |-> !supply_inhibit_output)
        else $error("left fail-safe before cooling");
    a_undervolt_safe: assert property (supply_uv_i |-> ##[1:4] !supply_inhibit_output)
        else $error("no fail-safe on undervoltage");
    a_overvolt_safe: assert property (
        regulator_ov_i |-> ##[1:4] (!supply_inhibit_output && !transceiver_regulator_o))
        else $error("no fail-safe on overvoltage");
    a_tx_path: assert property (
        tx_enable_o && !dominant_timeout_fault_i |-> tx_dominant_o == !txd_i)
        else $error("transmit path wrong");
    a_rx_path: assert property (rx_enable_o |-> rxd_o == !bus_dominant_i)
        else $error("receive path wrong");
    a_ready_mode: assert property (
        transceiver_ready_output |-> tx_enable_o && rx_enable_o)
        else $error("ready outside normal");
    a_ready_fault: assert property (
        dominant_timeout_fault_i [*3] |-> !transceiver_ready_output)
        else $error("ready during dominant fault");
    a_sleep_quiet: assert property (
        !supply_inhibit_output |-> !tx_enable_o && !rx_enable_o)
        else $error("transceiver on with inhibit off");
    a_host_power: assert property (s_host_up |-> transceiver_regulator_o)
        else $error("regulator off after normal request");
endmodule // tmc_core_chk

// File: tb/tmc_core_bench.sv
// self-checking bench of the transceiver mode controller with a host model
`timescale 1ns/10ps
`include "tmc_regs.svh"
module tmc_core_bench
    import tmc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic        bus_dominant_i = 1'b0, local_wake_i = 1'b0, over_temp_rise_i = 1'b0;
    logic        over_temp_fall_i = 1'b1, supply_uv_i = 1'b0, regulator_ov_i = 1'b0;
    logic        io_supply_valid_i = 1'b1, dominant_timeout_fault_i = 1'b0;
    logic        want_normal = 1'b0, answer_wake = 1'b0, tx_bit = 1'b1;
    logic        sleep_control_n, txd_i, rxd_o, rxd_oe, tx_dominant_o, tx_enable_o, wb_ack_o;
    logic        rx_enable_o, bus_bias_2v5_o, transceiver_regulator_o, supply_inhibit_output;
    logic        transceiver_ready_output;
    int          fail_count = 0, compares = 0;

    tmc_core #(.TICK_CYC(2), .SLP_TICKS(4), .SILENCE_TICKS(40), .INACT_TICKS(80),
               .WKFILT_TICKS(1), .WKTO_TICKS(20), .UVSLP_TICKS(40)) dut_u (
        .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .sleep_control_n, .txd_i, .bus_dominant_i, .local_wake_i,
        .over_temp_rise_i, .over_temp_fall_i, .supply_uv_i, .regulator_ov_i,
        .io_supply_valid_i, .dominant_timeout_fault_i, .rxd_o, .rxd_oe, .tx_dominant_o,
        .tx_enable_o, .rx_enable_o, .bus_bias_2v5_o, .transceiver_regulator_o,
        .supply_inhibit_output, .transceiver_ready_output);

    tmc_host_model host_u (.clk, .want_normal, .answer_wake, .tx_bit, .rxd_o, .rxd_oe,
        .sleep_control_n, .txd_i);

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic report_and_stop();
        $display("counts: compares=%0d mismatches=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle, held until ack is high at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            chk(32'h0000_0001, 32'h0000_0000, "ack wait");
            report_and_stop();
        end
    endtask

    // poll the status register until the mode field shows m
    task automatic wait_mode(input tmc_mode_t m);
        int n;
        n = 0;
        do begin
            wb(1'b0, `TMC_STAT_OFS, 32'h0000_0000);
            n++;
        end while (rd[3:0] !== m && n < 150);
        chk({28'h000_0000, rd[3:0]}, {28'h000_0000, m}, "mode");
        if (n >= 150) report_and_stop();
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // bus dominant, recessive, dominant for the given cycle counts
    task automatic pattern(input int d1, input int r, input int d2);
        @(posedge clk);
        bus_dominant_i <= 1'b1;
        repeat (d1) @(posedge clk);
        bus_dominant_i <= 1'b0;
        repeat (r) @(posedge clk);
        bus_dominant_i <= 1'b1;
        repeat (d2) @(posedge clk);
        bus_dominant_i <= 1'b0;
    endtask

    // fault gone: a local wake edge lets the host bring it back to normal
    task automatic recover();
        hold(2);
        @(posedge clk);
        local_wake_i <= !local_wake_i;
        wait_mode(TMC_NORMAL);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, `TMC_STAT_OFS, 32'h0000_0000);
        hold(0);
        chk(rd & 32'h0000_00ff, 32'h0000_0052, "status after reset");
        chk({31'h0, rxd_o}, 32'h0000_0000, "rxd after reset");
        wb(1'b0, `TMC_CTRL_OFS, 32'h0000_0000);
        chk(rd, `TMC_CTRL_RST, "ctrl reset");
        wb_sel_i <= 4'he;
        wb(1'b1, `TMC_CTRL_OFS, 32'h0000_0001);
        wb(1'b0, `TMC_CTRL_OFS, 32'h0000_0000);
        chk(rd, `TMC_CTRL_RST, "ctrl byte lane off");
        wb_sel_i <= 4'hf;
        wb(1'b1, 8'h10, 32'hffff_ffff);
        wb(1'b0, 8'h10, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        $display("test reset done");
        @(posedge clk);
        want_normal <= 1'b1;
        wait_mode(TMC_NORMAL);
        chk(rd & 32'h0000_00f0, 32'h0000_00e0, "normal status");
        @(posedge clk);
        tx_bit <= 1'b0;
        bus_dominant_i <= 1'b1;
        hold(2);
        chk({30'h0, tx_dominant_o, rxd_o}, 32'h0000_0002, "normal path");
        @(posedge clk);
        tx_bit <= 1'b1;
        bus_dominant_i <= 1'b0;
        dominant_timeout_fault_i <= 1'b1;
        hold(3);
        chk({31'h0, transceiver_ready_output}, 32'h0000_0000, "ready in fault");
        @(posedge clk);
        dominant_timeout_fault_i <= 1'b0;
        $display("test normal done");
        @(posedge clk);
        over_temp_fall_i <= 1'b0;
        over_temp_rise_i <= 1'b1;
        wait_mode(TMC_FAILSAFE);
        hold(0);
        chk({30'h0, tx_enable_o, rx_enable_o}, 32'h0000_0000, "hot path");
        @(posedge clk);
        over_temp_rise_i <= 1'b0;
        hold(10);
        wait_mode(TMC_FAILSAFE);
        @(posedge clk);
        over_temp_fall_i <= 1'b1;
        hold(6);
        wait_mode(TMC_FAILSAFE);
        recover();
        @(posedge clk);
        over_temp_rise_i <= 1'b1;
        wait_mode(TMC_FAILSAFE);
        @(posedge clk);
        over_temp_rise_i <= 1'b0;
        recover();
        @(posedge clk);
        supply_uv_i <= 1'b1;
        wait_mode(TMC_FAILSAFE);
        @(posedge clk);
        supply_uv_i <= 1'b0;
        recover();
        @(posedge clk);
        regulator_ov_i <= 1'b1;
        wait_mode(TMC_FAILSAFE);
        chk(rd & 32'h0000_0060, 32'h0000_0000, "overvoltage outputs");
        @(posedge clk);
        regulator_ov_i <= 1'b0;
        recover();
        $display("test faults done");
        @(posedge clk);
        want_normal <= 1'b0;
        wait_mode(TMC_SLEEP);
        hold(0);
        chk({30'h0, supply_inhibit_output, rx_enable_o}, 32'h0000_0000, "sleep pins");
        pattern(1, 1, 1);
        hold(10);
        wait_mode(TMC_SLEEP);
        pattern(8, 60, 8);
        hold(60);
        wait_mode(TMC_SLEEP);
        @(posedge clk);
        io_supply_valid_i <= 1'b0;
        pattern(8, 8, 8);
        hold(2);
        chk({31'h0, rxd_oe}, 32'h0000_0000, "rxd released");
        @(posedge clk);
        io_supply_valid_i <= 1'b1;
        hold(2);
        chk({30'h0, rxd_oe, rxd_o}, 32'h0000_0002, "wake on rxd");
        wait_mode(TMC_STANDBY);
        chk(rd & 32'h0000_0120, 32'h0000_0120, "bias and regulator");
        hold(90);
        wait_mode(TMC_STANDBY);
        chk(rd & 32'h0000_0020, 32'h0000_0000, "regulator after silence");
        wait_mode(TMC_SLEEP);
        $display("test bus wake done");
        @(posedge clk);
        answer_wake <= 1'b1;
        local_wake_i <= !local_wake_i;
        wait_mode(TMC_NORMAL);
        $display("test local wake done");
        report_and_stop();
    end
endmodule // tmc_core_bench

bind tmc_core tmc_core_chk chk_u (.clk, .rst_n, .sleep_control_n, .txd_i, .bus_dominant_i,
    .over_temp_rise_i, .over_temp_fall_i, .supply_uv_i, .regulator_ov_i, .io_supply_valid_i,
    .dominant_timeout_fault_i, .rxd_o, .tx_dominant_o, .tx_enable_o, .rx_enable_o,
    .transceiver_regulator_o, .supply_inhibit_output, .transceiver_ready_output);
